// ### src/retry_card_regs.sv
// Retry status and card control configuration registers with their routings
`timescale 1ns/10ps
`include "retry_card_map.svh"
// Function
// - Flag expiry after 2^15 cycles when enabled
// - Expired flags stay set until written 1
// - Bit 7 enables host retry counter
// - Bit 6 global card retry enable
// - Bit 5 shows card target B expiry
// - Bit 3 shows card target A expiry
// - Bit 1 shows host target expiry
// - Retry status bits 4,2,0 read zero
// - Global bits single, written via function 0
// - Ring enable gates all ring routings
// - Video enable tri-states socket video pins
// - Port select picks video priority socket
// - Card control bits 4,3 read zero
// - Audio to mux, socket 0 wins
// - Speaker output is XOR of enabled sockets
// - Speaker pin driven only when enabled
// - Per-socket interrupt flag, write 1 clears
module retry_card_regs
(
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_cfg_write,
	input wire logic i_cfg_read,
	input wire retry_card_pkg::function_type i_cfg_function,
	input wire logic [7:0] i_cfg_offset,
	input wire retry_card_pkg::cfg_byte_type i_cfg_wdata,
	output retry_card_pkg::cfg_byte_type o_cfg_rdata,
	input wire logic i_host_retried,
	input wire logic i_host_returned,
	input wire logic i_card_a_retried,
	input wire logic i_card_a_returned,
	input wire logic i_card_b_retried,
	input wire logic i_card_b_returned,
	output logic o_host_retry_counter_en,
	output logic o_card_retry_counter_en,
	input wire logic i_ring_indicate,
	input wire logic i_ring_mux_select,
	output logic o_ring_pme_out,
	output logic o_ring_to_multipurpose_pin_2,
	output logic o_ring_to_multipurpose_pin_4,
	output logic o_video_hiz_socket0,
	output logic o_video_hiz_socket1,
	output logic o_video_select_socket0,
	output logic o_video_select_socket1,
	input wire logic i_card_audio_signal0,
	input wire logic i_card_audio_signal1,
	output logic o_audio_pwm_function,
	input wire logic i_card_speaker_signal0,
	input wire logic i_card_speaker_signal1,
	output logic o_speaker_output_pin,
	output logic o_speaker_output_pin_oe,
	input wire logic i_card_irq0,
	input wire logic i_card_irq1
);
	import retry_card_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: three stages, a change counts when stages 2 and 3 agree
	logic [5:0] pin_s1;
	logic [5:0] pin_s2;
	logic [5:0] pin_s3;
	logic [5:0] pin_q;
	wire logic [5:0] pin_raw = {i_card_irq1, i_card_irq0, i_card_speaker_signal1, i_card_speaker_signal0,
		i_card_audio_signal1, i_card_audio_signal0};

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			pin_s1 <= 6'h00;
			pin_s2 <= 6'h00;
			pin_s3 <= 6'h00;
		end
		else
		begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	// Filtered value per pin
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++)
		begin : g_filt
			always_ff @(posedge i_mclk)
			begin
				if (!i_rstn)
					pin_q[gi] <= 1'b0;
				else if (pin_s2[gi] == pin_s3[gi])
					pin_q[gi] <= pin_s3[gi];
			end
		end
	endgenerate

	wire logic [1:0] audio_q = pin_q[1:0];
	wire logic [1:0] speaker_q = pin_q[3:2];
	wire logic [1:0] irq_q = pin_q[5:4];
	logic [1:0] irq_prev;

	////////////////////////////////////////////////////////////////////////
	// Register storage: global bits single, socket bits per function
	logic host_retry_counter_en; // per function 0 image only
	logic card_retry_counter_en;
	logic card_target_b_expired;
	logic card_target_a_expired;
	logic host_target_expired;
	logic ring_output_enable;
	logic [1:0] zoomed_video_enable;
	logic [1:0] port_select;
	logic [1:0] card_audio_to_mux;
	logic [1:0] speaker_out_enable;
	logic [1:0] card_function_irq_flag;

	// Access decode; global bits take writes only from function 0
	wire logic fn0 = (i_cfg_function == func0_type_sel);
	wire logic fn_idx = (i_cfg_function == func1_type_sel);
	wire logic hit_retry = (i_cfg_offset == `RETRY_STATUS_OFFSET);
	wire logic hit_card = (i_cfg_offset == `CARD_CONTROL_OFFSET);
	wire logic wr_retry = i_cfg_write && hit_retry && fn0;
	wire logic wr_card = i_cfg_write && hit_card;
	wire logic wr_card_global = wr_card && fn0;

	////////////////////////////////////////////////////////////////////////
	// Retry watchdogs: one for the host, one each for card targets A and B
	logic host_expire_pulse;
	logic card_a_expire_pulse;
	logic card_b_expire_pulse;

	retry_watchdog u_host_watch
	(
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_enable(host_retry_counter_en),
		.i_retried(i_host_retried),
		.i_returned(i_host_returned),
		.o_expired(host_expire_pulse)
	);

	retry_watchdog u_card_a_watch
	(
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_enable(card_retry_counter_en),
		.i_retried(i_card_a_retried),
		.i_returned(i_card_a_returned),
		.o_expired(card_a_expire_pulse)
	);

	retry_watchdog u_card_b_watch
	(
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_enable(card_retry_counter_en),
		.i_retried(i_card_b_retried),
		.i_returned(i_card_b_returned),
		.o_expired(card_b_expire_pulse)
	);

	////////////////////////////////////////////////////////////////////////
	// Sticky flag next values: set wins over a clearing write, zero writes ignored
	wire logic next_host_exp = host_expire_pulse ||
		(host_target_expired && !(wr_retry && i_cfg_wdata[`HOST_EXPIRED_BIT]));
	wire logic next_card_a_exp = card_a_expire_pulse ||
		(card_target_a_expired && !(wr_retry && i_cfg_wdata[`CARD_A_EXPIRED_BIT]));
	wire logic next_card_b_exp = card_b_expire_pulse ||
		(card_target_b_expired && !(wr_retry && i_cfg_wdata[`CARD_B_EXPIRED_BIT]));
	wire logic [1:0] irq_rise = irq_q & ~irq_prev;

	// Retry status register
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			host_retry_counter_en <= 1'b1;
			card_retry_counter_en <= 1'b1;
			host_target_expired <= 1'b0;
			card_target_a_expired <= 1'b0;
			card_target_b_expired <= 1'b0;
		end
		else
		begin
			if (wr_retry)
			begin
				host_retry_counter_en <= i_cfg_wdata[`HOST_RETRY_EN_BIT];
				card_retry_counter_en <= i_cfg_wdata[`CARD_RETRY_EN_BIT];
			end
			host_target_expired <= next_host_exp;
			card_target_a_expired <= next_card_a_exp;
			card_target_b_expired <= next_card_b_exp;
		end
	end

	// Global ring enable, written through function 0 only, read through both functions
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
			ring_output_enable <= 1'b0;
		else if (wr_card_global)
			ring_output_enable <= i_cfg_wdata[`RING_OUT_EN_BIT];
	end

	// Per-socket card control bits and interrupt flags
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_sock
			wire logic wr_this = wr_card && (fn_idx == 1'(gi));
			always_ff @(posedge i_mclk)
			begin
				if (!i_rstn)
				begin
					zoomed_video_enable[gi] <= 1'b0;
					port_select[gi] <= 1'b0;
					card_audio_to_mux[gi] <= 1'b0;
					speaker_out_enable[gi] <= 1'b0;
					card_function_irq_flag[gi] <= 1'b0;
					irq_prev[gi] <= 1'b0;
				end
				else
				begin
					irq_prev[gi] <= irq_q[gi];
					if (wr_this)
					begin
						zoomed_video_enable[gi] <= i_cfg_wdata[`VIDEO_EN_BIT];
						port_select[gi] <= i_cfg_wdata[`PORT_SELECT_BIT];
						card_audio_to_mux[gi] <= i_cfg_wdata[`AUDIO_MUX_BIT];
						speaker_out_enable[gi] <= i_cfg_wdata[`SPEAKER_EN_BIT];
					end
					// Rising interrupt sets; set beats a same-cycle clear
					card_function_irq_flag[gi] <= irq_rise[gi] ||
						(card_function_irq_flag[gi] && !(wr_this && i_cfg_wdata[`IRQ_FLAG_BIT]));
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Read data; reserved bits tie to zero
	wire logic [7:0] retry_view = {host_retry_counter_en, card_retry_counter_en, card_target_b_expired, 1'b0,
		card_target_a_expired, 1'b0, host_target_expired, 1'b0};
	wire logic [7:0] card_view = {ring_output_enable, zoomed_video_enable[fn_idx], port_select[fn_idx], 2'b00,
		card_audio_to_mux[fn_idx], speaker_out_enable[fn_idx], card_function_irq_flag[fn_idx]};
	wire logic [7:0] next_rdata = (hit_retry && fn0) ? retry_view : (hit_card ? card_view : 8'h00);

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
			o_cfg_rdata <= 8'h00;
		else if (i_cfg_read)
			o_cfg_rdata <= next_rdata;
	end

	////////////////////////////////////////////////////////////////////////
	// Routings. Port select is taken from function 0 as a single priority choice.
	wire logic both_video = &zoomed_video_enable;
	wire logic audio_pick = card_audio_to_mux[0] ? audio_q[0] : audio_q[1];
	wire logic [1:0] spk_masked = speaker_q & speaker_out_enable;
	logic next_speaker;

	always_comb
	begin
		next_speaker = ^spk_masked;
	end

	// Outputs registered to keep the pins glitch free
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			o_ring_pme_out <= 1'b0;
			o_ring_to_multipurpose_pin_2 <= 1'b0;
			o_ring_to_multipurpose_pin_4 <= 1'b0;
			o_video_hiz_socket0 <= 1'b0;
			o_video_hiz_socket1 <= 1'b0;
			o_video_select_socket0 <= 1'b0;
			o_video_select_socket1 <= 1'b0;
			o_audio_pwm_function <= 1'b0;
			o_speaker_output_pin <= 1'b0;
			o_speaker_output_pin_oe <= 1'b0;
		end
		else
		begin
			o_ring_pme_out <= ring_output_enable && !i_ring_mux_select && i_ring_indicate;
			o_ring_to_multipurpose_pin_2 <= ring_output_enable && i_ring_indicate;
			o_ring_to_multipurpose_pin_4 <= ring_output_enable && i_ring_indicate;
			o_video_hiz_socket0 <= zoomed_video_enable[0];
			o_video_hiz_socket1 <= zoomed_video_enable[1];
			o_video_select_socket0 <= zoomed_video_enable[0] && !(both_video && port_select[0]);
			o_video_select_socket1 <= zoomed_video_enable[1] && !(both_video && !port_select[0]);
			o_audio_pwm_function <= (|card_audio_to_mux) && audio_pick;
			o_speaker_output_pin <= next_speaker;
			o_speaker_output_pin_oe <= |speaker_out_enable;
		end
	end

	assign o_host_retry_counter_en = host_retry_counter_en;
	assign o_card_retry_counter_en = card_retry_counter_en;

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_host_flag_set: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		host_expire_pulse |=> host_target_expired) else $error("host expiry lost");
	a_flag_clear: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		wr_retry && i_cfg_wdata[`HOST_EXPIRED_BIT] && !host_expire_pulse |=> !host_target_expired)
		else $error("host flag not cleared");
	a_flag_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		card_target_a_expired && !(wr_retry && i_cfg_wdata[`CARD_A_EXPIRED_BIT]) |=> card_target_a_expired)
		else $error("card A flag dropped");
	// Checked on the read data itself, so a miswired view is caught too
	a_reserved_zero: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		i_cfg_read |=> (o_cfg_rdata & ($past(hit_retry) ? 8'h15 : 8'h18)) == 8'h00)
		else $error("reserved bit set");
	a_speaker_oe: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		##1 o_speaker_output_pin_oe == |$past(speaker_out_enable)) else $error("speaker enable wrong");
	a_speaker_xor: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		##1 o_speaker_output_pin == ^$past(spk_masked)) else $error("speaker data wrong");
	a_ring_block: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		!ring_output_enable |=> !o_ring_pme_out && !o_ring_to_multipurpose_pin_2 && !o_ring_to_multipurpose_pin_4)
		else $error("ring leaked");
	a_irq_set_wins: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		irq_rise[0] |=> card_function_irq_flag[0]) else $error("interrupt flag lost");
	a_retry_fn1_ro: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		i_cfg_write && hit_retry && !fn0 |=> $stable(host_retry_counter_en)) else $error("function 1 wrote");
endmodule : retry_card_regs

// ### src/retry_card_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RETRY_CARD_MAP_SVH
`define RETRY_CARD_MAP_SVH

`define RETRY_STATUS_OFFSET 8'h90
`define CARD_CONTROL_OFFSET 8'h91
`define RETRY_STATUS_RESET 8'hc0
`define CARD_CONTROL_RESET 8'h00
// Retry status fields
`define HOST_RETRY_EN_BIT 7
`define CARD_RETRY_EN_BIT 6
`define CARD_B_EXPIRED_BIT 5
`define CARD_A_EXPIRED_BIT 3
`define HOST_EXPIRED_BIT 1
// Card control fields
`define RING_OUT_EN_BIT 7
`define VIDEO_EN_BIT 6
`define PORT_SELECT_BIT 5
`define AUDIO_MUX_BIT 2
`define SPEAKER_EN_BIT 1
`define IRQ_FLAG_BIT 0
// Retry wait limit in PCI clock cycles, and counter width
`define RETRY_LIMIT_CYCLES 32768
`define RETRY_COUNT_WIDTH 16

`endif

// ### src/retry_card_pkg.sv
// Types shared by the retry status and card control block
package retry_card_pkg;
	typedef logic [7:0] cfg_byte_type;
	typedef enum logic {func0_type_sel, func1_type_sel} function_type;
	typedef enum {wait_idle, wait_count} retry_state_type;
endpackage : retry_card_pkg

// ### src/retry_watchdog.sv
// One retry timeout watchdog: counts while a retried master is away
`timescale 1ns/10ps
`include "retry_card_map.svh"
module retry_watchdog
(
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_enable,
	input wire logic i_retried,
	input wire logic i_returned,
	output logic o_expired
);
	import retry_card_pkg::*;

	retry_state_type state;
	retry_state_type next_state;
	logic [`RETRY_COUNT_WIDTH-1:0] count;
	logic [`RETRY_COUNT_WIDTH-1:0] next_count;
	logic next_expired;
	wire logic at_limit = (count == `RETRY_COUNT_WIDTH'(`RETRY_LIMIT_CYCLES - 1));

	// Next state; a disabled counter forgets any pending wait
	always_comb
	begin
		next_state = state;
		next_count = count;
		next_expired = 1'b0;
		case (state)
			wait_idle:
			begin
				next_count = '0;
				if (i_enable && i_retried)
					next_state = wait_count;
			end
			wait_count:
			begin
				next_count = count + 1'b1;
				if (!i_enable || i_returned)
					next_state = wait_idle;
				else if (at_limit)
				begin
					next_expired = 1'b1;
					next_state = wait_idle;
				end
			end
			default:
				next_state = wait_idle;
		endcase
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			state <= wait_idle;
			count <= '0;
			o_expired <= 1'b0;
		end
		else
		begin
			state <= next_state;
			count <= next_count;
			o_expired <= next_expired;
		end
	end
endmodule : retry_watchdog

// ### sim/retry_master_model.sv
// Behavioural bus master that gets retried and comes back after a set delay
`timescale 1ns/10ps
module retry_master_model
(
	input wire logic i_mclk,
	input wire logic i_start,
	input wire logic [15:0] i_return_after,
	output logic o_retried,
	output logic o_returned
);
	logic go;
	logic [15:0] left;

	initial
	begin
		o_retried = 1'b0;
		o_returned = 1'b0;
		left = 16'h0000;
	end

	////////////////////////////////////////////////////////////////
	// Sample on the edge, answer just after it; zero delay never returns
	always @(posedge i_mclk)
	begin
		go = i_start;
		#1;
		o_retried = go;
		o_returned = (left == 16'h0001);
		if (go)
			left = i_return_after;
		else if (left != 16'h0000)
			left = left - 16'h0001;
	end
endmodule : retry_master_model

// ### sim/retry_timeout_card_control_tb.sv
// Self-checking bench for the retry status and card control registers
`timescale 1ns/10ps
module retry_timeout_card_control_tb;
	import retry_card_pkg::*;
	logic i_mclk = 0, i_rstn = 0, i_cfg_write = 0, i_cfg_read = 0;
	function_type i_cfg_function = func0_type_sel;
	logic [7:0] i_cfg_offset = 8'h00;
	cfg_byte_type i_cfg_wdata = 8'h00;
	cfg_byte_type o_cfg_rdata;
	logic [2:0] go = 3'h0;
	logic [15:0] h_back = 16'h0000, a_back = 16'h0064, b_back = 16'h0000;
	logic [2:0] retried, returned;
	logic ring = 0, rmux = 0, aud0 = 0, aud1 = 0, spk0 = 0, spk1 = 0, irq0 = 0, irq1 = 0;
	logic h_en, c_en, pme, mp2, mp4, hiz0, hiz1, sel0, sel1, pwm, spk, spk_oe;
	int num_errors = 0;
	int cmp_count = 0;

	always #20 i_mclk = ~i_mclk;

	////////////////////////////////////////////////////////////////
	// Far-side masters: host, card target A, card target B
	retry_master_model host_master (.i_mclk(i_mclk), .i_start(go[0]), .i_return_after(h_back),
		.o_retried(retried[0]), .o_returned(returned[0]));
	retry_master_model card_a_master (.i_mclk(i_mclk), .i_start(go[1]), .i_return_after(a_back),
		.o_retried(retried[1]), .o_returned(returned[1]));
	retry_master_model card_b_master (.i_mclk(i_mclk), .i_start(go[2]), .i_return_after(b_back),
		.o_retried(retried[2]), .o_returned(returned[2]));

	retry_card_regs i_retry_card_regs (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_cfg_write(i_cfg_write),
		.i_cfg_read(i_cfg_read), .i_cfg_function(i_cfg_function), .i_cfg_offset(i_cfg_offset),
		.i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata), .i_host_retried(retried[0]),
		.i_host_returned(returned[0]), .i_card_a_retried(retried[1]), .i_card_a_returned(returned[1]),
		.i_card_b_retried(retried[2]), .i_card_b_returned(returned[2]), .o_host_retry_counter_en(h_en),
		.o_card_retry_counter_en(c_en), .i_ring_indicate(ring), .i_ring_mux_select(rmux),
		.o_ring_pme_out(pme), .o_ring_to_multipurpose_pin_2(mp2), .o_ring_to_multipurpose_pin_4(mp4),
		.o_video_hiz_socket0(hiz0), .o_video_hiz_socket1(hiz1), .o_video_select_socket0(sel0),
		.o_video_select_socket1(sel1), .i_card_audio_signal0(aud0), .i_card_audio_signal1(aud1),
		.o_audio_pwm_function(pwm), .i_card_speaker_signal0(spk0), .i_card_speaker_signal1(spk1),
		.o_speaker_output_pin(spk), .o_speaker_output_pin_oe(spk_oe), .i_card_irq0(irq0),
		.i_card_irq1(irq1));

	////////////////////////////////////////////////////////////////
	// Every task is entered 1 ns after an edge and leaves the same way
	task tick(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask : tick

	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task chk_bit(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask : chk_bit

	task wr(input logic fn, input logic [7:0] off, input logic [7:0] d);
		i_cfg_function = function_type'(fn);
		i_cfg_offset = off;
		i_cfg_wdata = d;
		i_cfg_write = 1;
		tick(1);
		i_cfg_write = 0;
		tick(1);
	endtask : wr

	// Data stands until the next read, so one spare edge costs nothing
	task rd(input logic fn, input logic [7:0] off, input logic [7:0] exp);
		i_cfg_function = function_type'(fn);
		i_cfg_offset = off;
		i_cfg_read = 1;
		tick(1);
		i_cfg_read = 0;
		tick(1);
		chk(o_cfg_rdata, exp);
	endtask : rd

	task conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////
	// Main sequence; card pins pass a sync filter, hence the 8-cycle waits
	initial
	begin
		tick(16);
		i_rstn = 1;
		chk_bit(h_en, 1);
		chk_bit(c_en, 1);
		rd(0, 8'h90, 8'hc0);
		rd(0, 8'h91, 8'h00);
		rd(1, 8'h91, 8'h00);
		rd(0, 8'h92, 8'h00);
		wr(0, 8'h90, 8'h3f);
		rd(0, 8'h90, 8'h00);
		chk_bit(c_en, 0);
		wr(1, 8'h90, 8'hc0);
		rd(0, 8'h90, 8'h00);
		rd(1, 8'h90, 8'h00);
		wr(0, 8'h90, 8'hc0);
		wr(0, 8'h91, 8'hff);
		rd(0, 8'h91, 8'he6);
		$display("register access test done");
		wr(0, 8'h91, 8'h00);
		wr(1, 8'h91, 8'h80);
		ring = 1;
		tick(2);
		chk_bit(pme, 0);
		chk_bit(mp4, 0);
		wr(0, 8'h91, 8'h80);
		tick(2);
		chk_bit(pme, 1);
		chk_bit(mp2, 1);
		rmux = 1;
		tick(2);
		chk_bit(pme, 0);
		chk_bit(mp4, 1);
		$display("ring routing test done");
		wr(0, 8'h91, 8'h40);
		wr(1, 8'h91, 8'h40);
		tick(2);
		chk({4'h0, hiz0, hiz1, sel0, sel1}, 8'h0e);
		wr(0, 8'h91, 8'h60);
		tick(2);
		chk({4'h0, hiz0, hiz1, sel0, sel1}, 8'h0d);
		wr(1, 8'h91, 8'h00);
		tick(2);
		chk({4'h0, hiz0, hiz1, sel0, sel1}, 8'h0a);
		$display("video test done");
		wr(0, 8'h91, 8'h00);
		spk0 = 1;
		aud1 = 1;
		tick(8);
		chk_bit(spk_oe, 0);
		wr(1, 8'h91, 8'h06);
		spk1 = 1;
		tick(8);
		chk({5'h00, spk_oe, spk, pwm}, 8'h07);
		wr(0, 8'h91, 8'h06);
		tick(2);
		chk({5'h00, spk_oe, spk, pwm}, 8'h04);
		$display("audio and speaker test done");
		wr(0, 8'h91, 8'h00);
		wr(1, 8'h91, 8'h00);
		irq0 = 1;
		tick(8);
		irq0 = 0;
		rd(0, 8'h91, 8'h01);
		rd(1, 8'h91, 8'h00);
		wr(0, 8'h91, 8'h00);
		rd(0, 8'h91, 8'h01);
		wr(0, 8'h91, 8'h01);
		rd(0, 8'h91, 8'h00);
		irq1 = 1;
		tick(8);
		irq1 = 0;
		rd(1, 8'h91, 8'h01);
		$display("interrupt flag test done");
		go = 3'h7;
		tick(1);
		go = 3'h0;
		tick(32760);
		rd(0, 8'h90, 8'hc0);
		tick(20);
		rd(0, 8'h90, 8'he2);
		wr(0, 8'h90, 8'he0);
		rd(0, 8'h90, 8'hc2);
		wr(0, 8'h90, 8'hc2);
		rd(0, 8'h90, 8'hc0);
		wr(0, 8'h90, 8'h40);
		a_back = 16'h0000;
		b_back = 16'h0064;
		go = 3'h7;
		tick(1);
		go = 3'h0;
		tick(32790);
		rd(0, 8'h90, 8'h48);
		$display("retry expiry test done");
		conclude();
	end
endmodule : retry_timeout_card_control_tb
